/* File: rsc_pkg.sv */
package rsc_pkg;

    // ***************************************************
    // Timing
    // ***************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PIN_DELAY_NS = 100;
    localparam int PIN_DELAY_CYC = (PIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_MIN_LOG2 = 10;
    localparam int OSC_MAX_LOG2 = 17;
    localparam int OPT_WAIT_US = 544;
    localparam int OPT_WAIT_CYC = OPT_WAIT_US * 1000 / CLK_PERIOD_NS;

    // ***************************************************
    // Register map and fields
    // ***************************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_FLAGS = 12'h004;
    localparam logic [11:0] ADDR_LV_CTRL = 12'h008;
    localparam logic [11:0] ADDR_LV_LEVEL = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam int CTRL_XTAL_BIT = 0;
    localparam int CTRL_OSC_LSB = 1;
    localparam int OSC_SEL_W = 3;
    localparam int FLAG_LV_BIT = 0;
    localparam int FLAG_WD_BIT = 1;
    localparam int LV_FLAG_BIT = 0;
    localparam int STAT_PC_LSB = 8;
    localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
    localparam logic [15:0] VEC_HI_ADDR = 16'h0001;
    localparam logic [7:0] BYTE_CLR = 8'h00;
    localparam logic [7:0] BYTE_SET = 8'hff;
    localparam logic [7:0] STATUS_WORD_RST = 8'h02;
    localparam logic [7:0] CLK_CTRL_RST = 8'h02;
    localparam logic [15:0] WORD_CLR = 16'h0000;

    typedef enum logic [5:0] {
        ST_RESET = 6'b000001,
        ST_OPT = 6'b000010,
        ST_OSC = 6'b000100,
        ST_VEC_LO = 6'b001000,
        ST_VEC_HI = 6'b010000,
        ST_RUN = 6'b100000
    } rsc_state_e;

    typedef struct packed {
        logic [7:0] processor_status_word;
        logic [7:0] port_latch;
        logic [7:0] port_direction_reg;
        logic [7:0] port_mode_control_reg;
        logic [7:0] pullup_enable_reg;
        logic [7:0] cpu_clock_control_reg;
        logic [7:0] pre_clock_control_reg;
        logic [7:0] lowosc_control_reg;
        logic [15:0] timer16_counter;
        logic [15:0] timer16_capcomp0;
        logic [15:0] timer16_capcomp1;
        logic [31:0] timer16_ctl;
        logic [7:0] timer8_compare0;
        logic [7:0] timer8_compare1;
        logic [7:0] timer8_mode_reg;
        logic [7:0] converter_mode_reg;
        logic [7:0] converter_channel_reg;
        logic [7:0] irq_request_flags;
        logic [7:0] irq_mask_reg;
        logic [7:0] ext_irq_edge_reg;
        logic [7:0] flash_status_reg;
        logic [7:0] flash_command_reg;
        logic [15:0] flash_ptr_compare;
        logic [7:0] flash_write_buffer;
    } rsc_periph_s;

    localparam rsc_periph_s PERIPH_RESET = '{
        processor_status_word: STATUS_WORD_RST, port_latch: BYTE_CLR, port_direction_reg: BYTE_SET,
        port_mode_control_reg: BYTE_CLR, pullup_enable_reg: BYTE_CLR,
        cpu_clock_control_reg: CLK_CTRL_RST, pre_clock_control_reg: CLK_CTRL_RST,
        lowosc_control_reg: BYTE_CLR, timer16_counter: WORD_CLR,
        timer16_capcomp0: WORD_CLR, timer16_capcomp1: WORD_CLR,
        timer16_ctl: {4{BYTE_CLR}}, timer8_compare0: BYTE_CLR,
        timer8_compare1: BYTE_CLR, timer8_mode_reg: BYTE_CLR,
        converter_mode_reg: BYTE_CLR, converter_channel_reg: BYTE_CLR,
        irq_request_flags: BYTE_CLR, irq_mask_reg: BYTE_SET,
        ext_irq_edge_reg: BYTE_CLR, flash_status_reg: BYTE_CLR,
        flash_command_reg: BYTE_CLR, flash_ptr_compare: WORD_CLR,
        flash_write_buffer: BYTE_CLR};

endpackage

/* File: rsc_ctrl.sv */
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// - Load PC from vectors at 0000H/0001H
// - Only PC undefined during reset and waits
// - RAM retained only when reset in standby
// - Status word becomes 02H, stack untouched
// - Port latches/mode/pullups 00H, directions FFH
// - Clock controls 02H, low oscillator 00H
// - 16-bit timer registers all cleared
// - 8-bit timer compares and mode cleared
// - Converter mode and channel cleared
// - Irq flags/edges cleared, mask set FFH
// - Flash status/command/compare/buffer cleared
// - Flags: pin/power-on clear, own source sets
// - Low-voltage registers kept on low-voltage reset
// - Pin reset follows pin after 100 ns
// - Crystal stops in reset, then stabilization wait
// - Option byte wait before execution starts
// - Port pins high impedance during reset
// - Watchdog reset also resets the watchdog
// - Reading flags, pin or power-on clears them
module rsc_ctrl #(
    parameter int OSC_BASE_LOG2 = rsc_pkg::OSC_MIN_LOG2,
    parameter int OPT_WAIT = rsc_pkg::OPT_WAIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_n,
    input wire logic power_on_detect,
    input wire logic lowvolt_detect,
    input wire logic wdog_overflow,
    input wire logic standby,
    output logic [15:0] vec_addr,
    input wire logic [7:0] vec_data,
    output logic [15:0] pc,
    output logic pc_valid,
    output logic internal_reset_n,
    output logic osc_run,
    output logic port_hiz,
    output logic wdog_timer_reset,
    output logic ram_retain,
    output logic periph_init,
    output rsc_pkg::rsc_periph_s periph_vals
);

    // ***************************************************
    // Input synchronisers
    // ***************************************************
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic pin_sync;
    logic pwr_on_s;
    logic lowvolt_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
        end else begin
            sync1 <= {~ext_reset_n, power_on_detect, lowvolt_detect};
            sync2 <= sync1;
        end
    end

    assign pin_sync = sync2[2];
    assign pwr_on_s = sync2[1];
    assign lowvolt_s = sync2[0];

    // ***************************************************
    // Pin delay
    // ***************************************************
    // A glitch shorter than the delay never reaches the core.
    logic pin_dly;
    logic [3:0] dly_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_dly <= 1'b1;
            dly_cnt <= 4'h0;
        end else if (pin_sync == pin_dly) begin
            dly_cnt <= 4'h0;
        end else if (dly_cnt == 4'(rsc_pkg::PIN_DELAY_CYC - 1)) begin
            pin_dly <= pin_sync;
            dly_cnt <= 4'h0;
        end else begin
            dly_cnt <= dly_cnt + 4'h1;
        end
    end

    pin_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(pin_dly) |-> pin_dly == $past(pin_sync, 10))
        else $error("pin reset did not follow pin after delay");

    logic any_src;
    logic clr_src;
    assign any_src = pin_dly | pwr_on_s | lowvolt_s | wdog_overflow;
    assign clr_src = pin_dly | pwr_on_s;

    // ***************************************************
    // Bus slave
    // ***************************************************
    logic ack;
    logic addr_ok;
    logic wr_done;
    logic rd_done;
    logic xtal_sel;
    logic [2:0] osc_sel;
    logic [1:0] flags;
    logic [7:0] lv_ctrl;
    logic [7:0] lv_level;
    rsc_pkg::rsc_state_e state;

    assign addr_ok = paddr == rsc_pkg::ADDR_CTRL || paddr == rsc_pkg::ADDR_FLAGS
        || paddr == rsc_pkg::ADDR_LV_CTRL || paddr == rsc_pkg::ADDR_LV_LEVEL
        || paddr == rsc_pkg::ADDR_STATUS;
    assign wr_done = psel & penable & ack & pwrite & addr_ok;
    assign rd_done = psel & penable & ack & ~pwrite;
    assign pready = ack;
    assign pslverr = ack & ~addr_ok;

    // One wait state so read data comes from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack <= 1'b0;
        end else begin
            ack <= psel & penable & ~ack;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & penable & ~ack & ~pwrite) begin
            unique case (paddr)
                rsc_pkg::ADDR_CTRL: begin
                    prdata <= 32'({osc_sel, xtal_sel});
                end
                rsc_pkg::ADDR_FLAGS: begin
                    prdata <= 32'(flags);
                end
                rsc_pkg::ADDR_LV_CTRL: begin
                    prdata <= 32'({lv_ctrl[7:1], lowvolt_s});
                end
                rsc_pkg::ADDR_LV_LEVEL: begin
                    prdata <= 32'(lv_level);
                end
                rsc_pkg::ADDR_STATUS: begin
                    prdata <= 32'({pc, 2'b00, state});
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Oscillator select is not touched by internal reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_sel <= 1'b0;
            osc_sel <= 3'h0;
        end else if (wr_done && paddr == rsc_pkg::ADDR_CTRL) begin
            xtal_sel <= pwdata[rsc_pkg::CTRL_XTAL_BIT];
            osc_sel <= pwdata[rsc_pkg::CTRL_OSC_LSB +: rsc_pkg::OSC_SEL_W];
        end
    end

    // ***************************************************
    // Reset source flags
    // ***************************************************
    logic [1:0] next_flags;

    always_comb begin
        next_flags = flags;
        if ((rd_done && paddr == rsc_pkg::ADDR_FLAGS) || clr_src) begin
            next_flags = 2'b00;
        end
        if (wdog_overflow && !clr_src) begin
            next_flags[rsc_pkg::FLAG_WD_BIT] = 1'b1;
        end
        if (lowvolt_s && !clr_src) begin
            next_flags[rsc_pkg::FLAG_LV_BIT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= 2'b00;
        end else begin
            flags <= next_flags;
        end
    end

    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        wdog_overflow && !clr_src |=> flags[rsc_pkg::FLAG_WD_BIT])
        else $error("watchdog flag not set");

    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && paddr == rsc_pkg::ADDR_FLAGS && !wdog_overflow && !lowvolt_s
        |=> flags == 2'b00)
        else $error("flag read did not clear flags");

    // ***************************************************
    // Low-voltage detector registers
    // ***************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_ctrl <= 8'h00;
            lv_level <= 8'h00;
        end else if (clr_src || wdog_overflow) begin
            lv_ctrl <= rsc_pkg::BYTE_CLR;
            lv_level <= rsc_pkg::BYTE_CLR;
        end else if (wr_done && paddr == rsc_pkg::ADDR_LV_CTRL) begin
            lv_ctrl <= {pwdata[7:1], 1'b0};
        end else if (wr_done && paddr == rsc_pkg::ADDR_LV_LEVEL) begin
            lv_level <= pwdata[7:0];
        end
    end

    lv_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        lowvolt_s && !clr_src && !wdog_overflow && !wr_done
        |=> $stable(lv_ctrl) && $stable(lv_level))
        else $error("low-voltage registers lost on own reset");

    // ***************************************************
    // Sequencer
    // ***************************************************
    logic [17:0] wait_cnt;
    logic wd_cause;

    function automatic logic [17:0] osc_limit(input logic [2:0] sel);
        osc_limit = 18'(1) << (OSC_BASE_LOG2 + int'(sel));
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= rsc_pkg::ST_RESET;
            wait_cnt <= 18'h0_0000;
        end else if (any_src) begin
            state <= rsc_pkg::ST_RESET;
            wait_cnt <= 18'h0_0000;
        end else begin
            unique case (state)
                rsc_pkg::ST_RESET: begin
                    state <= rsc_pkg::ST_OPT;
                    wait_cnt <= 18'h0_0000;
                end
                rsc_pkg::ST_OPT: begin
                    if (wait_cnt == 18'(OPT_WAIT - 1)) begin
                        state <= xtal_sel ? rsc_pkg::ST_OSC : rsc_pkg::ST_VEC_LO;
                        wait_cnt <= 18'h0_0000;
                    end else begin
                        wait_cnt <= wait_cnt + 18'h0_0001;
                    end
                end
                rsc_pkg::ST_OSC: begin
                    if (wait_cnt == osc_limit(osc_sel) - 18'h0_0001) begin
                        state <= rsc_pkg::ST_VEC_LO;
                    end else begin
                        wait_cnt <= wait_cnt + 18'h0_0001;
                    end
                end
                rsc_pkg::ST_VEC_LO: begin
                    state <= rsc_pkg::ST_VEC_HI;
                end
                rsc_pkg::ST_VEC_HI: begin
                    state <= rsc_pkg::ST_RUN;
                end
                rsc_pkg::ST_RUN: begin
                    state <= rsc_pkg::ST_RUN;
                end
            endcase
        end
    end

    src_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        any_src |=> state == rsc_pkg::ST_RESET ##1 state != rsc_pkg::ST_RUN)
        else $error("reset released while source active");

    opt_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == rsc_pkg::ST_RESET && !any_src |=> state == rsc_pkg::ST_OPT
        && wait_cnt == 18'h0_0000)
        else $error("option byte wait not entered");

    // Vector fetch: memory answers vec_data combinationally, in the same cycle as vec_addr.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_addr <= 16'h0000;
            pc <= 16'h0000;
        end else if (state == rsc_pkg::ST_VEC_LO) begin
            vec_addr <= rsc_pkg::VEC_HI_ADDR;
            pc[7:0] <= vec_data;
        end else if (state == rsc_pkg::ST_VEC_HI) begin
            pc[15:8] <= vec_data;
        end else if (state != rsc_pkg::ST_RUN) begin
            vec_addr <= rsc_pkg::VEC_LO_ADDR;
        end
    end

    vec_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == rsc_pkg::ST_VEC_LO && !any_src
        |=> vec_addr == rsc_pkg::VEC_HI_ADDR && pc[7:0] == $past(vec_data)
        ##1 pc[15:8] == $past(vec_data))
        else $error("program counter not loaded from vector");

    // ***************************************************
    // Reset outputs
    // ***************************************************
    // PC is only trustworthy once the sequence has finished.
    assign pc_valid = state == rsc_pkg::ST_RUN;
    assign internal_reset_n = state != rsc_pkg::ST_RESET;
    assign osc_run = !(xtal_sel && state == rsc_pkg::ST_RESET);
    assign port_hiz = state != rsc_pkg::ST_RUN;
    assign wdog_timer_reset = wd_cause & (state == rsc_pkg::ST_RESET);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cause <= 1'b0;
            ram_retain <= 1'b0;
        end else if (any_src && state != rsc_pkg::ST_RESET) begin
            wd_cause <= wdog_overflow;
            ram_retain <= standby;
        end else if (any_src) begin
            wd_cause <= wd_cause | wdog_overflow;
        end
    end

    hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == rsc_pkg::ST_OSC |-> port_hiz && !pc_valid)
        else $error("ports driven during oscillator wait");

    wd_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        wdog_overflow |=> wdog_timer_reset)
        else $error("watchdog not reset by own overflow");

    // Peripheral values are applied only at the end of the
    // sequence so other units keep their state until then.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_init <= 1'b0;
        end else begin
            periph_init <= state == rsc_pkg::ST_VEC_HI && !any_src;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_vals <= rsc_pkg::PERIPH_RESET;
        end else if (state == rsc_pkg::ST_VEC_HI) begin
            periph_vals <= rsc_pkg::PERIPH_RESET;
        end
    end

    init_vals_a: assert property (@(posedge pclk) disable iff (!presetn)
        periph_init |-> periph_vals.processor_status_word == rsc_pkg::STATUS_WORD_RST
        && periph_vals.port_direction_reg == rsc_pkg::BYTE_SET
        && periph_vals.irq_mask_reg == rsc_pkg::BYTE_SET
        && periph_vals.cpu_clock_control_reg == rsc_pkg::CLK_CTRL_RST
        && periph_vals.timer16_counter == rsc_pkg::WORD_CLR
        && pc_valid)
        else $error("peripheral reset values wrong at init");

    osc_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        xtal_sel && state == rsc_pkg::ST_RESET |-> !osc_run)
        else $error("crystal running during reset");

endmodule

/* File: rsc_src_model.sv */
`timescale 1ns/10ps
// ***************************************************
// Program memory holding the reset vector
// ***************************************************
module rsc_src_model (
    input wire logic pclk,
    input wire logic [15:0] vec_addr,
    output logic [7:0] vec_data
);
    logic [7:0] junk;

    // Outside the vector the bus toggles so a stray fetch cannot match by luck
    always @(posedge pclk) begin
        junk <= ~junk;
    end

    initial junk = 8'h5a;

    always_comb begin
        case (vec_addr)
            16'h0000: vec_data = 8'h34;
            16'h0001: vec_data = 8'h12;
            default: vec_data = junk;
        endcase
    end
endmodule

/* File: tb_reset_state_controller.sv */
`timescale 1ns/10ps
module tb_reset_state_controller;
    localparam int OPT_W = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ext_reset_n, power_on_detect, lowvolt_detect, wdog_overflow, standby;
    logic [15:0] vec_addr, pc;
    logic [7:0] vec_data;
    logic pc_valid, internal_reset_n, osc_run, port_hiz, wdog_timer_reset, ram_retain, periph_init;
    rsc_pkg::rsc_periph_s periph_vals;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    int n0, n1;

    rsc_ctrl #(.OSC_BASE_LOG2(2), .OPT_WAIT(OPT_W)) rsc_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_reset_n(ext_reset_n), .power_on_detect(power_on_detect), .lowvolt_detect(lowvolt_detect),
        .wdog_overflow(wdog_overflow), .standby(standby), .vec_addr(vec_addr),
        .vec_data(vec_data), .pc(pc), .pc_valid(pc_valid), .internal_reset_n(internal_reset_n),
        .osc_run(osc_run), .port_hiz(port_hiz), .wdog_timer_reset(wdog_timer_reset),
        .ram_retain(ram_retain), .periph_init(periph_init), .periph_vals(periph_vals));

    rsc_src_model rsc_src_model_i (.pclk(pclk), .vec_addr(vec_addr), .vec_data(vec_data));

    // ***************************************************
    // Checking and reporting
    // ***************************************************
    task automatic conclude;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles > 6000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ***************************************************
    // Bus and sequence helpers
    // ***************************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        chk("apb_err", (a > rsc_pkg::ADDR_STATUS) ? 1 : 0, pslverr);
        chk("apb_ready", 1, pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
    endtask

    // Waits for execution to start, checks the vector and the reset values in the
    // first run cycle, then returns on a clock edge so that callers drive there
    task automatic wait_run;
        int n;
        n = 0;
        #1;
        while (pc_valid !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("pc", 32'h0000_1234, pc);
        chk("port_hiz", 0, port_hiz);
        chk("int_rst", 1, internal_reset_n);
        chk("periph_init", 1, periph_init);
        chk("status_word", 32'h0000_0002, periph_vals.processor_status_word);
        chk("port_dir", 32'h0000_00ff, periph_vals.port_direction_reg);
        chk("cpu_clk", 32'h0000_0002, periph_vals.cpu_clock_control_reg);
        chk("irq_mask", 32'h0000_00ff, periph_vals.irq_mask_reg);
        chk("periph", 1, periph_vals === rsc_pkg::PERIPH_RESET);
        @(posedge pclk);
    endtask

    // Watchdog reset held for five cycles; returns cycles from release to execution
    task automatic wdog_rst(input logic exp_osc, output int cnt);
        @(posedge pclk);
        wdog_overflow <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk("wdog_tmr_rst", 1, wdog_timer_reset);
        chk("hiz_in_rst", 1, port_hiz);
        chk("osc_run", exp_osc, osc_run);
        repeat (2) @(posedge pclk);
        wdog_overflow <= 1'b0;
        #1;
        cnt = 0;
        while (internal_reset_n !== 1'b1 && cnt < 100) begin
            @(posedge pclk);
            #1;
            cnt++;
        end
        cnt = 0;
        while (pc_valid !== 1'b1 && cnt < 2000) begin
            @(posedge pclk);
            #1;
            cnt++;
        end
        wait_run();
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ***************************************************
    // Scenarios
    // ***************************************************
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        {ext_reset_n, power_on_detect, lowvolt_detect, wdog_overflow, standby} = 5'b10000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk("hiz_boot", 1, port_hiz);
        wait_run();
        rd_chk("flags_por", rsc_pkg::ADDR_FLAGS, 32'h0000_0000);
        rd_chk("status", rsc_pkg::ADDR_STATUS, 32'h0012_3420);
        rd_chk("unmapped", 12'h020, 32'h0000_0000);
        // Low-voltage reset keeps its own registers
        apb(1'b1, rsc_pkg::ADDR_LV_CTRL, 32'h0000_0082);
        apb(1'b1, rsc_pkg::ADDR_LV_LEVEL, 32'h0000_0005);
        lowvolt_detect <= 1'b1;
        repeat (40) @(posedge pclk);
        #1;
        chk("rst_held", 0, internal_reset_n);
        rd_chk("lv_live", rsc_pkg::ADDR_LV_CTRL, 32'h0000_0083);
        lowvolt_detect <= 1'b0;
        wait_run();
        rd_chk("lv_ctrl_kept", rsc_pkg::ADDR_LV_CTRL, 32'h0000_0082);
        rd_chk("lv_lvl_kept", rsc_pkg::ADDR_LV_LEVEL, 32'h0000_0005);
        // Watchdog reset in standby: lv flag held, wd flag set, lv regs cleared
        standby <= 1'b1;
        wdog_rst(1'b1, n0);
        chk("ram_keep", 1, ram_retain);
        standby <= 1'b0;
        rd_chk("flags_wd_lv", rsc_pkg::ADDR_FLAGS, 32'h0000_0003);
        rd_chk("flags_rdclr", rsc_pkg::ADDR_FLAGS, 32'h0000_0000);
        rd_chk("lv_ctrl_clr", rsc_pkg::ADDR_LV_CTRL, 32'h0000_0000);
        rd_chk("lv_lvl_clr", rsc_pkg::ADDR_LV_LEVEL, 32'h0000_0000);
        wdog_rst(1'b1, n0);
        chk("ram_lost", 0, ram_retain);
        chk("opt_wait", OPT_W + 2, n0);
        // Pin reset follows the pin after a delay, both ways, and clears the flags
        ext_reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
        #1;
        chk("pin_dly_on", 1, internal_reset_n);
        repeat (15) @(posedge pclk);
        ext_reset_n <= 1'b1;
        #1;
        chk("pin_rst", 0, internal_reset_n);
        repeat (5) @(posedge pclk);
        #1;
        chk("pin_dly_off", 0, internal_reset_n);
        wait_run();
        rd_chk("flags_pin", rsc_pkg::ADDR_FLAGS, 32'h0000_0000);
        // Crystal selected: oscillator stops and 2^(2+1) extra cycles pass
        apb(1'b1, rsc_pkg::ADDR_CTRL, 32'h0000_0003);
        rd_chk("ctrl", rsc_pkg::ADDR_CTRL, 32'h0000_0003);
        wdog_rst(1'b0, n1);
        chk("osc_wait", 8, n1 - n0);
        // Power-on clear wipes the watchdog flag
        power_on_detect <= 1'b1;
        repeat (10) @(posedge pclk);
        power_on_detect <= 1'b0;
        wait_run();
        rd_chk("flags_pwron", rsc_pkg::ADDR_FLAGS, 32'h0000_0000);
        conclude();
    end
endmodule
